// ===== src/out_clock_gen.sv
// one output clock: divider of the tuned crystal clock with full-period gating
// assumes cfg is registered on sys_clk; half is the high (and low) time in cycles
`timescale 1ns/100ps

module out_clock_gen
  import refhold_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // requested setting
  input wire out_cfg_t cfg,
  // clock out
  output logic clk_out
);

  out_cfg_t act_ff;
  logic [7:0] cnt_ff;
  logic out_ff;

  // settings are taken only at the end of a low half, so a change never cuts a pulse
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      act_ff <= '0;
      cnt_ff <= 8'h00;
      out_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (cnt_ff != 8'h00)
      begin
        cnt_ff <= cnt_ff - 8'h01;
      end
      else if (!out_ff)
      begin
        act_ff <= cfg;
        out_ff <= cfg.en && (cfg.half != 8'h00);
        cnt_ff <= (cfg.half == 8'h00) ? 8'h00 : cfg.half - 8'h01;
      end
      else
      begin
        out_ff <= 1'b0;
        cnt_ff <= act_ff.half - 8'h01;
      end
    end
  end

  assign clk_out = out_ff;

endmodule

// ===== src/pin_sync.sv
// three-stage synchroniser with agreement filter and rising edge detect
// assumes asynchronous pins; a bit changes once stages two and three agree
`timescale 1ns/100ps

module pin_sync #(
  parameter int W = 7
)
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // pins
  input wire logic [W-1:0] pin,
  // filtered level and rise pulse
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;
  logic [W-1:0] rise_ff;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else if (ce)
    begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // only the agreeing later stages are looked at
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lvl_ff <= '0;
      rise_ff <= '0;
    end
    else if (ce)
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_ff[i] == s3_ff[i])
        begin
          lvl_ff[i] <= s3_ff[i];
          rise_ff[i] <= s3_ff[i] & ~lvl_ff[i];
        end
        else
        begin
          rise_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign lvl = lvl_ff;
  assign rise = rise_ff;

endmodule

// ===== src/ref_holdover_clock_fanout.sv
// control logic of a zero-delay clock buffer with reference holdover
// assumes sys_clk is the tuned crystal oscillator; all pins arrive asynchronously
`timescale 1ns/100ps
`include "refhold_consts.svh"

module ref_holdover_clock_fanout
  import refhold_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // reference pins
  input wire logic primary_ref_in,
  input wire logic secondary_ref_in,
  input wire logic ref_choice,
  input wire logic [3:0] ratio_sel,
  // status
  output logic ref_valid,
  output logic holdover,
  output logic [7:0] tune_code,
  // clock outputs
  output logic [3:0] group_a_out,
  output logic [3:0] group_b_out
);

  // ****************************************************************
  // constants at working width
  // ****************************************************************
  localparam logic [7:0] FSL = 8'(`FSL_CYC);
  localparam logic [7:0] FSH = 8'(`FSH_CYC);
  localparam logic [7:0] PER_MIN = 8'(`REF_PER_MIN_CYC);
  localparam logic [7:0] PER_MAX = 8'(`REF_PER_MAX_CYC);
  localparam logic [7:0] LOOP_PER = 8'(`LOOP_PER_CYC);
  localparam logic [7:0] CNT_SAT = 8'hFE;

  // ****************************************************************
  // output map functions
  // ****************************************************************
  function automatic logic [5:0] out_ratio(input logic [3:0] sel, input int idx);
    logic grp_b;
    logic low_pair;
    logic [5:0] r;
    grp_b = (idx >= 4);
    low_pair = ((idx % 4) < 2);
    r = 6'd0;
    unique case (sel)
      4'h0: r = 6'd32;
      4'h1: r = (!grp_b && low_pair) ? 6'd0 : 6'd32;
      4'h2: r = grp_b ? 6'd32 : 6'd0;
      4'h3: r = grp_b ? 6'd32 : (low_pair ? 6'd0 : 6'd16);
      4'h4: r = (grp_b && !low_pair) ? 6'd32 : 6'd0;
      4'h5: r = grp_b ? 6'd32 : (low_pair ? 6'd8 : 6'd16);
      4'h6: r = grp_b ? 6'd16 : 6'd8;
      4'h7: r = grp_b ? 6'd20 : (low_pair ? 6'd1 : 6'd10);
      default: r = 6'd0;
    endcase
    return r;
  endfunction

  // half period in cycles is the base divided by the ratio
  function automatic out_cfg_t make_cfg(input logic [3:0] sel, input int idx);
    out_cfg_t c;
    logic [5:0] r;
    r = out_ratio(sel, idx);
    c.en = (r != 6'd0);
    case (r)
      6'd1: c.half = 8'(`OUT_BASE_HALF / 1);
      6'd8: c.half = 8'(`OUT_BASE_HALF / 8);
      6'd10: c.half = 8'(`OUT_BASE_HALF / 10);
      6'd16: c.half = 8'(`OUT_BASE_HALF / 16);
      6'd20: c.half = 8'(`OUT_BASE_HALF / 20);
      6'd32: c.half = 8'(`OUT_BASE_HALF / 32);
      default: c.half = 8'h00;
    endcase
    return c;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pin_bus_t pin_lvl;
  pin_bus_t pin_rise;
  logic [6:0] lvl_vec;
  logic [6:0] rise_vec;

  pin_sync #(.W(7)) u_pin_sync
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .pin({ratio_sel, ref_choice, secondary_ref_in, primary_ref_in}),
    .lvl(lvl_vec),
    .rise(rise_vec)
  );

  assign pin_lvl = pin_bus_t'(lvl_vec);
  assign pin_rise = pin_bus_t'(rise_vec);

  // ****************************************************************
  // reference pick and period measurement
  // ****************************************************************
  logic sel_edge;
  logic choice_d_ff;
  logic chg;
  logic [7:0] cnt_ff;
  logic [7:0] per_ff;
  logic seen_ff;
  logic [7:0] period_now;
  logic timeout;
  logic good_edge;
  logic bad_edge;

  assign sel_edge = pin_lvl.choice ? pin_rise.primary : pin_rise.secondary;
  assign chg = (pin_lvl.choice != choice_d_ff);
  assign period_now = cnt_ff + 8'h01;
  // no edge within the last period plus the margin means the reference is gone
  assign timeout = seen_ff && ({1'b0, period_now} >= ({1'b0, per_ff} + {1'b0, FSL}));
  // the crystal runs at the fixed ratio, so the period must fit the capture range
  assign good_edge = sel_edge && seen_ff && !pin_lvl.ratio_sel[`SEL_OFF_BIT]
    && (period_now >= PER_MIN) && (period_now <= PER_MAX);
  assign bad_edge = sel_edge && seen_ff && !good_edge;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      choice_d_ff <= 1'b0;
      cnt_ff <= 8'h00;
      per_ff <= PER_MAX;
      seen_ff <= 1'b0;
    end
    else if (ce)
    begin
      choice_d_ff <= pin_lvl.choice;
      if (chg || timeout)
      begin
        seen_ff <= 1'b0;
        per_ff <= PER_MAX;
        cnt_ff <= 8'h00;
      end
      else if (sel_edge)
      begin
        seen_ff <= 1'b1;
        cnt_ff <= 8'h00;
        per_ff <= good_edge ? period_now : PER_MAX;
      end
      else if (cnt_ff != CNT_SAT)
      begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  // ****************************************************************
  // loop state
  // ****************************************************************
  loop_state_t state_ff;
  loop_state_t nxt_state;
  logic arm_ff;
  logic [7:0] wait_ff;
  logic fault;

  assign fault = chg || timeout || bad_edge;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_ACQUIRE:
      begin
        if (!fault && !good_edge && arm_ff && (wait_ff == FSH - 8'h01))
        begin
          nxt_state = ST_TRACK;
        end
      end
      ST_TRACK:
      begin
        if (fault)
        begin
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (sel_edge)
        begin
          nxt_state = ST_ACQUIRE;
        end
      end
      default:
      begin
        nxt_state = ST_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= ST_ACQUIRE;
      arm_ff <= 1'b0;
      wait_ff <= 8'h00;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      if (state_ff != ST_ACQUIRE || fault)
      begin
        arm_ff <= 1'b0;
        wait_ff <= 8'h00;
      end
      else if (good_edge)
      begin
        arm_ff <= 1'b1;
        wait_ff <= 8'h00;
      end
      else if (arm_ff)
      begin
        wait_ff <= wait_ff + 8'h01;
      end
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  logic valid_ff;
  logic hold_ff;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      valid_ff <= 1'b0;
      hold_ff <= 1'b0;
    end
    else if (ce)
    begin
      valid_ff <= (nxt_state == ST_TRACK);
      hold_ff <= (nxt_state == ST_HOLD);
    end
  end

  assign ref_valid = valid_ff;
  assign holdover = hold_ff;

  // ****************************************************************
  // tuning code and local phase
  // ****************************************************************
  logic [7:0] tune_ff;
  logic [7:0] lph_ff;

  // local phase restarts on entry to tracking; the edge lies FSH+1 cycles back
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lph_ff <= 8'h00;
    end
    else if (ce)
    begin
      if (state_ff == ST_ACQUIRE && nxt_state == ST_TRACK)
      begin
        lph_ff <= FSH + 8'h01;
      end
      else if (lph_ff >= LOOP_PER - 8'h01)
      begin
        lph_ff <= 8'h00;
      end
      else
      begin
        lph_ff <= lph_ff + 8'h01;
      end
    end
  end

  // one step per in-range edge in tracking, none at local phase zero; the code saturates at the ends of the pull span
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tune_ff <= `TUNE_RESET;
    end
    else if (ce && state_ff == ST_TRACK && nxt_state == ST_TRACK && good_edge)
    begin
      if (lph_ff != 8'h00 && lph_ff < (LOOP_PER >> 1))
      begin
        if (tune_ff != `TUNE_LO)
        begin
          tune_ff <= tune_ff - 8'h01;
        end
      end
      else if (lph_ff != 8'h00)
      begin
        if (tune_ff != `TUNE_HI)
        begin
          tune_ff <= tune_ff + 8'h01;
        end
      end
    end
  end

  assign tune_code = tune_ff;

  // ****************************************************************
  // output configuration and clock generators
  // ****************************************************************
  out_cfg_t cfg_ff [8];
  logic [7:0] clk_all;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        cfg_ff[i] <= '0;
      end
    end
    else if (ce)
    begin
      for (int i = 0; i < 8; i++)
      begin
        cfg_ff[i] <= make_cfg(pin_lvl.ratio_sel, i);
      end
    end
  end

  // outputs never see a reference pin, only the tuned crystal clock
  for (genvar g = 0; g < 8; g++)
  begin : g_out
    out_clock_gen u_out
    (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .cfg(cfg_ff[g]),
      .clk_out(clk_all[g])
    );
  end

  assign group_a_out = clk_all[3:0];
  assign group_b_out = clk_all[7:4];

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [7:0] low_run_ff;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      low_run_ff <= 8'h00;
    end
    else if (ce)
    begin
      if (valid_ff)
      begin
        low_run_ff <= 8'h00;
      end
      else if (low_run_ff != 8'hFF)
      begin
        low_run_ff <= low_run_ff + 8'h01;
      end
    end
  end

  sequence s_loss;
    ce && state_ff == ST_TRACK && timeout;
  endsequence

  sequence s_bad;
    ce && state_ff == ST_TRACK && bad_edge;
  endsequence

  sequence s_return;
    (ce && state_ff == ST_ACQUIRE && good_edge && !chg)
    ##1 (ce && !chg && !sel_edge)[*4];
  endsequence

  property p_valid_track;
    @(posedge sys_clk) disable iff (!rstn)
    ref_valid |-> (!holdover && seen_ff);
  endproperty
  a_valid_track: assert property (p_valid_track) else $error("valid without tracked edges");

  property p_hold_freeze;
    @(posedge sys_clk) disable iff (!rstn)
    (state_ff != ST_TRACK) |=> $stable(tune_code);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("tuning moved out of track");

  property p_loss_flag;
    @(posedge sys_clk) disable iff (!rstn)
    s_loss |=> (!ref_valid && holdover && $stable(tune_code));
  endproperty
  a_loss_flag: assert property (p_loss_flag) else $error("loss not flagged");

  property p_tune_gate;
    @(posedge sys_clk) disable iff (!rstn)
    !(ce && good_edge) |=> $stable(tune_code);
  endproperty
  a_tune_gate: assert property (p_tune_gate) else $error("tuning without in-range edge");

  property p_out_of_range;
    @(posedge sys_clk) disable iff (!rstn)
    s_bad |=> !ref_valid;
  endproperty
  a_out_of_range: assert property (p_out_of_range) else $error("bad period kept valid");

  property p_tune_step;
    @(posedge sys_clk) disable iff (!rstn)
    $changed(tune_code) |-> (tune_code == $past(tune_code) + 8'h01)
      || (tune_code == $past(tune_code) - 8'h01);
  endproperty
  a_tune_step: assert property (p_tune_step) else $error("tuning jumped");

  property p_resume;
    @(posedge sys_clk) disable iff (!rstn)
    s_return |=> (ref_valid && lph_ff == FSH + 8'h01);
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after return");

  property p_deadline;
    @(posedge sys_clk) disable iff (!rstn)
    ref_valid |-> ({1'b0, period_now} <= ({1'b0, per_ff} + {1'b0, FSL}));
  endproperty
  a_deadline: assert property (p_deadline) else $error("valid past failure deadline");

  property p_return_hold;
    @(posedge sys_clk) disable iff (!rstn)
    $rose(ref_valid) |-> ($past(low_run_ff) >= PER_MIN + FSH);
  endproperty
  a_return_hold: assert property (p_return_hold) else $error("valid raised too early");

  property p_ratio_off;
    @(posedge sys_clk) disable iff (!rstn)
    (ce && pin_lvl.ratio_sel[`SEL_OFF_BIT]) |=> (!cfg_ff[0].en && !cfg_ff[7].en
      && !cfg_ff[2].en && !cfg_ff[5].en);
  endproperty
  a_ratio_off: assert property (p_ratio_off) else $error("output enabled for 1xxx");

endmodule

// ===== src/refhold_consts.svh
// constants of the reference holdover clock fanout: timing counts, ranges, reset values
// assumes sys_clk is the tuned crystal clock at 125 MHz (8 ns)
`ifndef REFHOLD_CONSTS_SVH
`define REFHOLD_CONSTS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 8
`define FAIL_MARGIN_NS 25
// assert delay is a longest time: round down
`define FSL_CYC (`FAIL_MARGIN_NS / `CLK_PERIOD_NS)
// deassert delay is a least time: round up
`define FSH_CYC ((`FAIL_MARGIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// capture range of the reference period
// ****************************************************************
`define REF_PER_MIN_NS 244
`define REF_PER_MAX_NS 261
`define REF_PER_MIN_CYC (`REF_PER_MIN_NS / `CLK_PERIOD_NS)
`define REF_PER_MAX_CYC ((`REF_PER_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// loop and tuning
// ****************************************************************
`define XTAL_RATIO 4
`define XTAL_PER_CYC 8
`define LOOP_PER_CYC (`XTAL_RATIO * `XTAL_PER_CYC)
`define TUNE_SPAN_PPM 100
`define TUNE_RESET 8'h80
`define TUNE_LO 8'h00
`define TUNE_HI 8'hFF
`define SEL_OFF_BIT 3
`define OUT_BASE_HALF 160

`endif

// ===== src/refhold_pkg.sv
// types shared by the reference holdover clock fanout
// assumes nothing beyond a SystemVerilog compiler
package refhold_pkg;

  typedef enum logic [1:0]
  {
    ST_ACQUIRE = 2'b00,
    ST_TRACK = 2'b01,
    ST_HOLD = 2'b11
  } loop_state_t;

  typedef struct packed
  {
    logic en;
    logic [7:0] half;
  } out_cfg_t;

  typedef struct packed
  {
    logic [3:0] ratio_sel;
    logic choice;
    logic secondary;
    logic primary;
  } pin_bus_t;

endpackage

// ===== tb/ref_source_model.sv
// two free-running reference clock sources for the reference pins
// assumes a stopped source leaves its pin to the pin pull-down (low)
`timescale 1ns/100ps

module ref_source_model
(
  // controls
  input wire logic run_p,
  input wire logic run_s,
  input wire logic [15:0] per_p,
  input wire logic [15:0] per_s,
  // pins
  output logic primary_ref_in,
  output logic secondary_ref_in
);
  // a period in flight always completes, so a stop never leaves a runt on the pin
  always
  begin
    if (run_p)
    begin
      primary_ref_in = 1'b1;
      #(per_p / 2);
      primary_ref_in = 1'b0;
      #(per_p - per_p / 2);
    end
    else
    begin
      primary_ref_in = 1'b0;
      #1;
    end
  end

  always
  begin
    if (run_s)
    begin
      secondary_ref_in = 1'b1;
      #(per_s / 2);
      secondary_ref_in = 1'b0;
      #(per_s - per_s / 2);
    end
    else
    begin
      secondary_ref_in = 1'b0;
      #1;
    end
  end
endmodule

// ===== tb/testbench.sv
// self-checking bench of the reference holdover clock fanout
// assumes ref_source_model drives the reference pins; sys_clk is 125 MHz
`timescale 1ns/100ps
`include "refhold_consts.svh"

module testbench;
  logic sys_clk, rstn, ce, ref_choice, run_p, run_s, ref_valid, holdover, counting;
  logic [3:0] ratio_sel, group_a_out, group_b_out;
  logic [15:0] per_p, per_s;
  logic [7:0] tune_code, prev_o;
  wire logic primary_ref_in, secondary_ref_in;
  wire logic [7:0] outs = {group_b_out, group_a_out};
  int errors = 0;
  int num_checks = 0;
  int cnt [8];
  int hi_len [8];
  realtime last_rise;

  ref_source_model src
  (
    .run_p(run_p),
    .run_s(run_s),
    .per_p(per_p),
    .per_s(per_s),
    .primary_ref_in(primary_ref_in),
    .secondary_ref_in(secondary_ref_in)
  );

  ref_holdover_clock_fanout DUT
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .primary_ref_in(primary_ref_in),
    .secondary_ref_in(secondary_ref_in),
    .ref_choice(ref_choice),
    .ratio_sel(ratio_sel),
    .ref_valid(ref_valid),
    .holdover(holdover),
    .tune_code(tune_code),
    .group_a_out(group_a_out),
    .group_b_out(group_b_out)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // monitors and model
  // ****************************************************************
  initial prev_o = 8'h00;
  initial counting = 1'b0;
  always @(posedge primary_ref_in) last_rise = $realtime;

  // a high run shorter than the fastest half period would be a runt
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (outs[i] && !prev_o[i] && counting)
        cnt[i]++;
      if (!outs[i] && prev_o[i])
        chk_int("high_run_ok", 1, int'(hi_len[i] >= 5));
      hi_len[i] = outs[i] ? hi_len[i] + 1 : 0;
    end
    prev_o = outs;
  end

  function automatic int exp_half(input int c, input int o);
    int r;
    case (c)
      0: r = 32;
      1: r = o < 2 ? 0 : 32;
      2: r = o < 4 ? 0 : 32;
      3: r = o < 2 ? 0 : (o < 4 ? 16 : 32);
      4: r = o < 6 ? 0 : 32;
      5: r = o < 2 ? 8 : (o < 4 ? 16 : 32);
      6: r = o < 4 ? 8 : 16;
      7: r = o < 2 ? 1 : (o < 4 ? 10 : 20);
      default: r = 0;
    endcase
    return r == 0 ? 0 : `OUT_BASE_HALF / r;
  endfunction

  task automatic chk_int(input string what, input int exp, input int got);
    num_checks++;
    if (exp != got)
    begin
      errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  task automatic chk_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wait_valid(input logic lvl, input int lim);
    int n;
    n = 0;
    while (ref_valid !== lvl && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_bits("ref_valid", {7'h00, lvl}, {7'h00, ref_valid});
  endtask

  // 1600 cycles hold a whole number of periods of every output ratio
  task automatic measure();
    foreach (cnt[i]) cnt[i] = 0;
    counting = 1'b1;
    cycles(1600);
    counting = 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    // tests need at most about 40k cycles; the watchdog at 62.5k cycles lies well above
    #500_000;
    errors++;
    $display("test watchdog expired");
    summarize();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    int n, per, hl;
    logic [7:0] tc, os;
    realtime t0;
    rstn = 1'b0;
    ce = 1'b1;
    ref_choice = 1'b1;
    ratio_sel = 4'h0;
    run_p = 1'b0;
    run_s = 1'b0;
    per_p = 16'd256;
    per_s = 16'd256;
    void'($urandom(52760));
    cycles(4);
    chk_bits("status", 8'h00, {6'h00, ref_valid, holdover});
    chk_bits("tune_code", `TUNE_RESET, tune_code);
    rstn = 1'b1;
    per = $urandom_range(258, 248);
    per_p = per[15:0];
    run_p = 1'b1;
    wait_valid(1'b1, 300);
    per_p = 16'd252;
    n = 0;
    repeat (2000)
    begin
      @(negedge sys_clk);
      if (tune_code !== `TUNE_RESET)
        n = 1;
    end
    chk_int("tune_moved", 1, n);
    // clock enable low must freeze tuning, flags and outputs
    ce = 1'b0;
    tc = tune_code;
    os = outs;
    cycles(50);
    chk_bits("frozen_tune", tc, tune_code);
    chk_bits("frozen_outs", os, outs);
    chk_bits("frozen_valid", 8'h01, {7'h00, ref_valid});
    ce = 1'b1;
    $display("test lock and tune done");
    per_p = 16'd256;
    for (int c = 0; c < 16; c++)
    begin
      ratio_sel = c[3:0];
      cycles(400);
      measure();
      for (int i = 0; i < 8; i++)
      begin
        hl = exp_half(c, i);
        chk_int($sformatf("edges c%0d o%0d", c, i), hl == 0 ? 0 : 1600 / (2 * hl), cnt[i]);
      end
      if (c > 7)
        chk_bits("ref_valid", 8'h00, {7'h00, ref_valid});
    end
    ratio_sel = 4'h0;
    wait_valid(1'b1, 600);
    $display("test ratio table done");
    run_p = 1'b0;
    wait_valid(1'b0, 200);
    chk_int("loss_delay_ok", 1, int'($realtime - last_rise > per_p &&
      $realtime - last_rise <= per_p + `FAIL_MARGIN_NS + 7 * `CLK_PERIOD_NS));
    chk_bits("holdover", 8'h01, {7'h00, holdover});
    tc = tune_code;
    measure();
    chk_bits("tune_code", tc, tune_code);
    chk_int("holdover_edges", 160, cnt[7]);
    run_p = 1'b1;
    t0 = $realtime;
    wait_valid(1'b1, 300);
    chk_int("return_hold_ok", 1, int'($realtime - t0 >= per_p + `FAIL_MARGIN_NS));
    chk_bits("holdover", 8'h00, {7'h00, holdover});
    $display("test loss and return done");
    for (int k = 0; k < 2; k++)
    begin
      per_p = (k == 0) ? 16'd300 : 16'd200;
      wait_valid(1'b0, 300);
      tc = tune_code;
      cycles(200);
      chk_bits("tune_code", tc, tune_code);
      per_p = 16'd256;
      wait_valid(1'b1, 400);
    end
    $display("test capture range done");
    cycles($urandom_range(31, 0));
    run_s = 1'b1;
    ref_choice = 1'b0;
    cycles(100);
    wait_valid(1'b1, 400);
    run_p = 1'b0;
    n = 0;
    repeat (400)
    begin
      @(negedge sys_clk);
      if (ref_valid !== 1'b1)
        n++;
    end
    chk_int("valid_drops", 0, n);
    run_s = 1'b0;
    wait_valid(1'b0, 200);
    $display("test reference choice done");
    summarize();
  end
endmodule
